// >>> hw/dial_pkg.sv
// constants shared by the dial stepper sequencer
package dial_pkg;
    localparam int clk_hz = 10_000_000;
    localparam int coil_count = 4;
    localparam int band_steps = 40;
    localparam int group_pulses = 4;
    localparam int band_time_ms = 350;
    localparam int osc_period_cycles = (clk_hz / 1000) * band_time_ms / band_steps;
    localparam int line_hz = 60;
    localparam int cont_fast_s = 6;
    localparam int cont_slow_s = 20;
    localparam int div_fast = cont_fast_s * line_hz / band_steps;
    localparam int div_slow = cont_slow_s * line_hz / band_steps;
    localparam int dwell_min_s = 1;
    localparam int dwell_max_s = 60;
    localparam int one_second_cycles = clk_hz;
    localparam logic [3:0] coil_phase0 = 4'h1;
    localparam logic [3:0] coils_off = 4'h0;
    typedef enum logic [1:0] {src_timer, src_contactor, src_remote} dwell_src_type;
endpackage

// >>> hw/step_pulse_div.sv
// counts input pulses and emits one pulse every n of them
`timescale 1ns/1ps
module step_pulse_div #(
    parameter int width = 16
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // control
    input wire logic i_clear,
    input wire logic i_tick,
    input wire logic [width-1:0] i_div,
    // output
    output logic o_pulse
);
    logic [width-1:0] count_reg;
    logic [width-1:0] count_next;
    logic pulse_reg;
    logic pulse_next;

    always_comb begin
        count_next = count_reg;
        pulse_next = 1'b0;
        if (i_clear) begin
            count_next = '0;
        end else if (i_tick) begin
            if (count_reg + width'(1) >= i_div) begin
                count_next = '0;
                pulse_next = 1'b1;
            end else begin
                count_next = count_reg + width'(1);
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            count_reg <= '0;
            pulse_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            pulse_reg <= pulse_next;
        end
    end

    assign o_pulse = pulse_reg;
endmodule

// >>> hw/dial_stepper_sequencer.sv
// coil sequencer and motion control for the dial stepper
`timescale 1ns/1ps
module dial_stepper_sequencer
    import dial_pkg::*;
#(
    parameter int osc_cycles = osc_period_cycles,
    parameter int second_cycles = one_second_cycles
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // operator panel
    input wire logic i_start,
    input wire logic i_stop,
    input wire logic i_reverse,
    input wire logic i_continuous,
    input wire logic i_slow_speed,
    input wire logic [1:0] i_dwell_source,
    input wire logic [5:0] i_dwell_seconds,
    // external pins
    input wire logic i_line_60hz,
    input wire logic i_contactor,
    input wire logic i_remote_advance,
    // motor coils and status
    output logic [3:0] o_coils,
    output logic o_running,
    output logic o_band_done
);
    typedef enum logic [1:0] {st_idle, st_band, st_dwell, st_cont} state_type;

    // pin synchronisers
    logic [1:0] line_sync_reg, cont_sync_reg, rem_sync_reg;
    logic [1:0] line_sync_next, cont_sync_next, rem_sync_next;
    logic line_prev_reg, cont_prev_reg, rem_prev_reg;
    logic line_rise, cont_rise, rem_rise;

    state_type state_reg, state_next;
    logic [1:0] phase_reg, phase_next;
    logic [3:0] coils_reg, coils_next;
    logic [5:0] step_reg, step_next;
    logic [23:0] osc_reg, osc_next;
    logic [27:0] sec_reg, sec_next;
    logic [5:0] dwell_reg, dwell_next;
    logic done_reg, done_next;
    logic cont_pulse, step_pulse, trigger, dwell_expired;
    logic [5:0] dwell_limit;
    logic [7:0] div_sel;
    logic [1:0] coil_idx;
    logic group_edge;

    always_comb begin
        line_sync_next = {line_sync_reg[0], i_line_60hz};
        cont_sync_next = {cont_sync_reg[0], i_contactor};
        rem_sync_next = {rem_sync_reg[0], i_remote_advance};
    end

    assign line_rise = line_sync_reg[1] & ~line_prev_reg;
    assign cont_rise = cont_sync_reg[1] & ~cont_prev_reg;
    assign rem_rise = rem_sync_reg[1] & ~rem_prev_reg;

    // line divider for continuous mode
    assign div_sel = i_slow_speed ? 8'(div_slow) : 8'(div_fast);
    step_pulse_div #(.width(8)) u_line_div (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_clear(state_reg != st_cont),
        .i_tick(line_rise),
        .i_div(div_sel),
        .o_pulse(cont_pulse)
    );

    // dwell limit clamped to 1..60 s
    always_comb begin
        dwell_limit = i_dwell_seconds;
        if (i_dwell_seconds < 6'(dwell_min_s)) begin
            dwell_limit = 6'(dwell_min_s);
        end else if (i_dwell_seconds > 6'(dwell_max_s)) begin
            dwell_limit = 6'(dwell_max_s);
        end
    end
    assign dwell_expired = (dwell_reg >= dwell_limit);

    always_comb begin
        trigger = 1'b0;
        case (dwell_src_type'(i_dwell_source))
            src_timer: trigger = dwell_expired;
            src_contactor: trigger = cont_rise;
            src_remote: trigger = rem_rise;
            default: trigger = rem_rise;
        endcase
    end

    // step pulse source selection
    always_comb begin
        step_pulse = 1'b0;
        case (state_reg)
            st_band: step_pulse = (osc_reg == 24'(osc_cycles - 1));
            st_cont: step_pulse = cont_pulse;
            default: step_pulse = 1'b0;
        endcase
    end

    // phase is the next forward coil; reverse fires two back from it
    assign coil_idx = i_reverse ? phase_reg - 2'h2 : phase_reg;

    // stop only on a whole group of four steps
    assign group_edge = (step_reg[1:0] == 2'h0) && !step_pulse;

    always_comb begin
        state_next = state_reg;
        phase_next = phase_reg;
        coils_next = coils_off;
        step_next = step_reg;
        osc_next = '0;
        sec_next = '0;
        dwell_next = dwell_reg;
        done_next = 1'b0;
        if (state_reg == st_band) begin
            osc_next = step_pulse ? 24'h000000 : osc_reg + 24'h000001;
        end
        if (state_reg == st_dwell) begin
            if (sec_reg == 28'(second_cycles - 1)) begin
                sec_next = '0;
                if (!dwell_expired) begin
                    dwell_next = dwell_reg + 6'h01;
                end
            end else begin
                sec_next = sec_reg + 28'h0000001;
            end
        end
        if (step_pulse) begin
            coils_next = coil_phase0 << coil_idx;
            phase_next = i_reverse ? phase_reg - 2'h1 : phase_reg + 2'h1;
            step_next = step_reg + 6'h01;
        end
        case (state_reg)
            st_idle: begin
                if (i_start && !i_stop) begin
                    step_next = '0;
                    state_next = i_continuous ? st_cont : st_band;
                end
            end
            st_band: begin
                if (step_pulse && step_reg == 6'(band_steps - 1)) begin
                    state_next = st_dwell;
                    dwell_next = '0;
                    done_next = 1'b1;
                end else if (i_stop && group_edge) begin
                    state_next = st_idle;
                end
            end
            st_dwell: begin
                if (i_stop) begin
                    state_next = st_idle;
                end else if (trigger) begin
                    step_next = '0;
                    state_next = st_band;
                end
            end
            st_cont: begin
                if (i_stop && group_edge) begin
                    state_next = st_idle;
                end
            end
            default: state_next = st_idle;
        endcase
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            line_sync_reg <= 2'h0;
            cont_sync_reg <= 2'h0;
            rem_sync_reg <= 2'h0;
            line_prev_reg <= 1'b0;
            cont_prev_reg <= 1'b0;
            rem_prev_reg <= 1'b0;
            state_reg <= st_idle;
            phase_reg <= 2'h0;
            coils_reg <= coils_off;
            step_reg <= '0;
            osc_reg <= '0;
            sec_reg <= '0;
            dwell_reg <= '0;
            done_reg <= 1'b0;
        end else begin
            line_sync_reg <= line_sync_next;
            cont_sync_reg <= cont_sync_next;
            rem_sync_reg <= rem_sync_next;
            line_prev_reg <= line_sync_reg[1];
            cont_prev_reg <= cont_sync_reg[1];
            rem_prev_reg <= rem_sync_reg[1];
            state_reg <= state_next;
            phase_reg <= phase_next;
            coils_reg <= coils_next;
            step_reg <= step_next;
            osc_reg <= osc_next;
            sec_reg <= sec_next;
            dwell_reg <= dwell_next;
            done_reg <= done_next;
        end
    end

    assign o_coils = coils_reg;
    assign o_running = (state_reg == st_band) || (state_reg == st_cont);
    assign o_band_done = done_reg;
endmodule

// >>> verif/dial_checker_assertions.sv
// assertions on the ports of the dial stepper sequencer
`timescale 1ns/1ps
module dial_checker
    import dial_pkg::*;
#(
    parameter int osc_cycles = 5,
    parameter int second_cycles = 20
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // panel
    input wire logic i_stop,
    input wire logic i_reverse,
    input wire logic i_continuous,
    // outputs
    input wire logic [3:0] o_coils,
    input wire logic o_running,
    input wire logic o_band_done
);
    logic [3:0] last_reg;
    logic rev_reg;
    logic [5:0] cnt_reg;
    logic [23:0] gap_reg;
    wire pulse = o_coils != coils_off;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    // last coil seen (rotor starts on the last coil), direction behind the coil shown, clocks since last coil
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            last_reg <= 4'h8;
            rev_reg <= 1'h0;
            cnt_reg <= 6'h0;
            gap_reg <= 24'h0;
        end else begin
            rev_reg <= i_reverse;
            last_reg <= pulse ? o_coils : last_reg;
            cnt_reg <= (!o_running && !pulse) ? 6'h0 : cnt_reg + 6'(pulse);
            gap_reg <= pulse ? 24'h1 : ((&gap_reg) ? gap_reg : gap_reg + 24'h1);
        end
    end
    chk_one_coil: assert property (pulse |-> $onehot(o_coils))
        else $error("more than one coil");
    chk_fwd_order: assert property (pulse && !rev_reg |-> o_coils == {last_reg[2:0], last_reg[3]})
        else $error("forward order broken");
    chk_rev_order: assert property (pulse && rev_reg |-> o_coils == {last_reg[0], last_reg[3:1]})
        else $error("reverse order broken");
    chk_rest_off: assert property (!o_running [*3] |-> o_coils == coils_off)
        else $error("coil on at rest");
    chk_pulse_width: assert property (pulse |=> !pulse)
        else $error("coil pulse too long");
    chk_band_count: assert property (o_band_done |-> pulse && cnt_reg == 6'h27)
        else $error("band not 40 steps");
    chk_step_rate: assert property (pulse && cnt_reg != 6'h0 && !i_continuous |-> gap_reg == 24'(osc_cycles))
        else $error("stepped rate wrong");
    chk_stop_hold: assert property (i_stop && !o_running |=> !o_running)
        else $error("motion despite stop");
    chk_halt_band: assert property (o_band_done |-> !o_running ##1 (o_coils == coils_off) [*4])
        else $error("no halt after band");
    cover property (o_band_done);
    cover property (pulse && i_reverse);
    cover property (pulse && i_continuous);
endmodule
bind dial_stepper_sequencer dial_checker #(
    .osc_cycles(osc_cycles),
    .second_cycles(second_cycles)
) i_chk (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_stop(i_stop),
    .i_reverse(i_reverse),
    .i_continuous(i_continuous),
    .o_coils(o_coils),
    .o_running(o_running),
    .o_band_done(o_band_done)
);

// >>> verif/dial_motor_model.sv
// stepper motor and cam contactor model
`timescale 1ns/1ps
module dial_motor_model (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // coils and cam request
    input wire logic [3:0] i_coils,
    input wire logic i_cam,
    // contactor and rotor position
    output logic o_contactor,
    output int o_pos
);
    logic [3:0] rotor_reg;
    int hold_reg;
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            rotor_reg <= 4'h8;
            o_pos <= 0;
            hold_reg <= 0;
        end else begin
            if (i_coils == {rotor_reg[2:0], rotor_reg[3]}) o_pos <= o_pos + 1;
            if (i_coils == {rotor_reg[0], rotor_reg[3:1]}) o_pos <= o_pos - 1;
            if (i_coils != 4'h0) rotor_reg <= i_coils;
            hold_reg <= i_cam ? 8 : (hold_reg > 0 ? hold_reg - 1 : 0);
        end
    end
    // closes once per cam request, then open and pulled low
    assign o_contactor = hold_reg > 0;
endmodule

// >>> verif/dial_stepper_sequencer_tb.sv
// testbench for the dial stepper sequencer
`timescale 1ns/1ps
module dial_stepper_sequencer_tb;
    import dial_pkg::*;
    logic i_mclk = 0, i_rst = 1, i_start = 0, i_stop = 0, i_reverse = 0, i_continuous = 0, i_slow_speed = 0;
    logic [1:0] i_dwell_source = 0;
    logic [5:0] i_dwell_seconds = 1;
    logic i_line_60hz = 0, i_remote_advance = 0, cam = 0, i_contactor;
    logic [3:0] o_coils;
    logic o_running, o_band_done;
    int o_pos, num_errors = 0, n_checks = 0, n_pulse = 0, gap, w, d, p0;
    always #50 i_mclk = ~i_mclk;
    // line period of 40 clocks
    always #2000 i_line_60hz = ~i_line_60hz;
    always @(negedge i_mclk) n_pulse += int'(o_coils != 4'h0);
    dial_stepper_sequencer #(.osc_cycles(5), .second_cycles(20)) i_dut (.*);
    dial_motor_model i_motor (.i_mclk, .i_rst, .i_coils(o_coils), .i_cam(cam), .o_contactor(i_contactor), .o_pos);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // expected dwell in clocks, clamped like the panel control
    function automatic int dwell_clocks(input int s);
        if (s < dwell_min_s) return dwell_min_s * 20;
        if (s > dwell_max_s) return dwell_max_s * 20;
        return s * 20;
    endfunction
    // clocks until the next coil pulse, capped
    task automatic next_pulse(output int n);
        n = 0;
        do begin
            @(negedge i_mclk);
            n++;
        end while (o_coils === 4'h0 && n < 9000);
    endtask
    initial begin
        #2_000_000;
        num_errors++;
        give_verdict;
    end
    initial begin
        void'($urandom(59));
        repeat (8) @(negedge i_mclk);
        i_rst = 0;
        i_start = 1;
        @(negedge i_mclk);
        i_start = 0;
        for (int b = 0; b < 6; b++) begin
            p0 = o_pos;
            i_dwell_source = (b == 5) ? 2'h3 : 2'(b % 3);
            i_dwell_seconds = (b == 0) ? 6'h00 : 6'($urandom_range(1, 63));
            // the first step of a later band was already seen at the end of the dwell
            repeat (b == 0 ? 40 : 39) next_pulse(gap);
            check(o_band_done, 1);
            @(negedge i_mclk);
            check(o_pos - p0, i_reverse ? -40 : 40);
            i_reverse = 1'($urandom_range(1));
            d = dwell_clocks(i_dwell_seconds);
            w = 30 + $urandom_range(60);
            if (b % 3 == 0) begin
                next_pulse(gap);
                check(gap > d && gap < d + 30, 1);
            end else begin
                repeat (w) @(negedge i_mclk);
                check(o_coils | o_running, 0);
                if (b % 3 == 1) cam = 1;
                else i_remote_advance = 1;
                @(negedge i_mclk);
                cam = 0;
                next_pulse(gap);
                check(gap < 20, 1);
                i_remote_advance = 0;
            end
        end
        repeat (39) next_pulse(gap);
        i_stop = 1;
        @(negedge i_mclk);
        i_stop = 0;
        i_remote_advance = 1;
        repeat (60) begin
            @(negedge i_mclk);
            check(o_coils | o_running, 0);
        end
        i_remote_advance = 0;
        i_continuous = 1;
        i_slow_speed = 1'($urandom_range(1));
        p0 = n_pulse;
        i_start = 1;
        @(negedge i_mclk);
        i_start = 0;
        next_pulse(gap);
        next_pulse(gap);
        check(gap, (i_slow_speed ? div_slow : div_fast) * 40);
        i_stop = 1;
        for (w = 0; w < 6000 && o_running; w++) @(negedge i_mclk);
        repeat (4) @(negedge i_mclk);
        check(o_running, 0);
        check((n_pulse - p0) % 4, 0);
        // stop in the middle of a stepped band
        i_stop = 0;
        i_continuous = 0;
        p0 = n_pulse;
        i_start = 1;
        @(negedge i_mclk);
        i_start = 0;
        repeat (6) next_pulse(gap);
        i_stop = 1;
        repeat (40) @(negedge i_mclk);
        check(o_running, 0);
        check(n_pulse - p0, 8);
        give_verdict;
    end
endmodule
